// *** verilog/rx_wb_pkg.sv ***
// package: write-back descriptor field layout, codes and register map
package rx_wb_pkg;
    // hash type codes
    localparam logic [3:0] HASH_NONE = 4'h0;
    localparam logic [3:0] HASH_LAST_VALID = 4'h9;
    // packet type field positions
    localparam int PT_VLAN_BIT = 12;
    localparam int PT_L2_BIT = 11;
    localparam int PT_TCP_BIT = 4;
    localparam int PT_UDP_BIT = 5;
    localparam int PT_SCTP_BIT = 6;
    // extended status bit positions
    localparam int ST_DONE = 0;
    localparam int ST_EOP = 1;
    localparam int ST_VLAN_STRIP = 3;
    localparam int ST_UDP_DONE = 4;
    localparam int ST_L4_DONE = 5;
    localparam int ST_IP_DONE = 6;
    localparam int ST_INEXACT = 7;
    localparam int ST_OUTER_VLAN = 9;
    localparam int ST_FRAG_UDP = 10;
    localparam int ST_LLI = 11;
    localparam int ST_CRC_STRIP = 12;
    localparam int ST_INLINE_TS = 15;
    localparam int ST_SYNC_TS = 16;
    // extended error bit positions
    localparam int ER_DATA = 11;
    localparam int ER_IP = 10;
    localparam int ER_L4 = 9;
    localparam int ER_HDR_OVF = 3;
    // descriptor type select codes
    localparam logic [2:0] DT_SPLIT = 3'h2;
    localparam logic [2:0] DT_REPL = 3'h3;
    localparam logic [2:0] DT_REPL_LARGE = 3'h4;
    localparam logic [2:0] DT_SPLIT_ALWAYS = 3'h5;
    // inline timestamp size in bytes
    localparam logic [15:0] INLINE_TS_BYTES = 16'h0010;
    // apb register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_WORD0_LO = 12'h008;
    localparam logic [11:0] REG_WORD0_HI = 12'h00c;
    localparam logic [11:0] REG_WORD1_LO = 12'h010;
    localparam logic [11:0] REG_WORD1_HI = 12'h014;
    localparam logic [11:0] REG_COUNT = 12'h018;
    // control register bit positions and reset value
    localparam int CT_CSUM_DIS = 0;
    localparam int CT_IPP_EN = 1;
    localparam int CT_DVLAN = 2;
    localparam int CT_STRIP_CRC = 3;
    localparam int CT_TYPE_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0011;

    // per-descriptor facts from the parse, hash and checksum engines
    typedef struct packed {
        logic lastDesc;
        logic firstDesc;
        logic [3:0] hashType;
        logic [12:0] pktType;
        logic [9:0] hdrLen;
        logic hdrFits;
        logic [15:0] bufLen;
        logic [15:0] pktLen;
        logic [31:0] rssHash;
        logic [15:0] fragSum;
        logic [15:0] ipId;
        logic [15:0] vlanTag;
        logic vlanStrip;
        logic outerVlan;
        logic ipSumDone;
        logic ipSumBad;
        logic l4Done;
        logic l4Bad;
        logic udpSumDone;
        logic fragUdpHdr;
        logic inexact;
        logic lliHit;
        logic crcStripped;
        logic syncTs;
        logic inlineTs;
        logic dataErr;
        logic splitUsed;
    } rx_facts_t;

    typedef struct packed {
        logic [63:0] word1;
        logic [63:0] word0;
    } wb_desc_t;
endpackage : rx_wb_pkg

// *** verilog/rx_descriptor_writeback_format.sv ***
// module: advanced receive descriptor write-back assembler with apb view
//
// Summary of operation
// R1 - 4-bit hash type, 0 none, 1..9 hash kinds, A..F reserved.
// R2 - packet-type bit 12 flags a VLAN-tagged packet.
// R3 - bit 11 clear: bits 7:0 are header presence flags, 10:8 reserved.
// R4 - bit 11 set: low bits hold matched EtherType filter index.
// R5 - 10-bit header length valid only in first descriptor; software ignores later.
// R6 - inline timestamp adds 16 bytes to header and buffer lengths.
// R7 - replication mode sets split flag; length reports parsed header size.
// R8 - split flag when header found; always-use with zero length reports packet size.
// R9 - checksum enabled: fragment sum in 63:48, IP id in 47:32.
// R10 - checksum disable set: 32-bit hash fills the shared field.
// R11 - non-last descriptor: only done and end-of-packet (clear) meaningful.
// R12 - status bit 16 marks a sync packet timestamped in registers.
// R13 - status bit 15 marks timestamp placed in receive buffer.
// R14 - status bits 2, 8, 13, 14, 17, 18, 19 always zero.
// R15 - status bit 5 marks L4 check run, last descriptor only.
// R16 - status bit 9 marks outer VLAN, only with double VLAN enabled.
// R17 - status bit 10 marks nonzero UDP sum in first fragment; else clear.
// R18 - status bit 11 marks a low-latency interrupt hit.
// R19 - status bit 12 marks CRC stripped per strip control.
// R20 - error bits 11, 10, 9, 3 as data, IP, L4, header overflow.
// R21 - header overflow when header exceeds buffer, only with split flag.
// R22 - 16-bit buffer length incl CRC; small type-4 packet gives packet size.
// R23 - VLAN tag kept in network order: priority, CFI, identifier.
// R24 - done and end-of-packet together only when packet complete.
// R25 - descriptor built as two 64-bit words.
`timescale 1ns/1ps
module rx_descriptor_writeback_format
    import rx_wb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic factsValid,
    input wire rx_wb_pkg::rx_facts_t facts,
    input wire logic [9:0] header_buffer_size,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic descValid,
    output rx_wb_pkg::wb_desc_t desc
);
    import rx_wb_pkg::*;

    logic [31:0] ctrl;
    logic [15:0] descCount;
    logic checksum_disable_ctl;
    logic ip_payload_sum_enable;
    logic double_vlan_enable;
    logic strip_crc_ctl;
    logic [2:0] descriptor_type_select;
    logic replMode;
    logic alwaysMode;
    logic header_overflow;
    logic split_header_flag;
    logic [9:0] parsed_header_length;
    logic [15:0] packet_buffer_length;
    logic [31:0] sharedField;
    logic [19:0] extStatus;
    logic [11:0] extError;
    logic [12:0] pktTypeOut;
    logic [3:0] hashOut;
    wb_desc_t next_desc;

    // control fields taken from the software control register
    assign checksum_disable_ctl = ctrl[CT_CSUM_DIS];
    assign ip_payload_sum_enable = ctrl[CT_IPP_EN];
    assign double_vlan_enable = ctrl[CT_DVLAN];
    assign strip_crc_ctl = ctrl[CT_STRIP_CRC];
    assign descriptor_type_select = ctrl[CT_TYPE_LSB +: 3];
    assign replMode = (descriptor_type_select == DT_REPL) ||
                      (descriptor_type_select == DT_REPL_LARGE);
    assign alwaysMode = (descriptor_type_select == DT_SPLIT_ALWAYS);

    // field assembly for one descriptor
    always_comb begin
        // reserved hash codes are reported as no hash
        hashOut = (facts.hashType > HASH_LAST_VALID) ? HASH_NONE : facts.hashType; // [R1]
        pktTypeOut = facts.pktType;
        if (facts.pktType[PT_L2_BIT]) begin
            pktTypeOut[10:3] = 8'h00; // [R4]
        end else begin
            pktTypeOut[10:8] = 3'h0; // [R3]
        end
        pktTypeOut[PT_VLAN_BIT] = facts.pktType[PT_VLAN_BIT]; // [R2]
        // header overflow only when the header did not fit a used split buffer
        header_overflow = facts.splitUsed && !facts.hdrFits; // [R21]
        split_header_flag = facts.splitUsed && (replMode || facts.hdrFits ||
                            alwaysMode || header_overflow); // [R7] [R8]
        parsed_header_length = facts.hdrLen; // [R7]
        packet_buffer_length = facts.bufLen; // [R22]
        if (descriptor_type_select == DT_REPL_LARGE &&
            facts.pktLen < {6'h00, header_buffer_size}) begin
            packet_buffer_length = facts.pktLen; // [R22]
        end
        if (alwaysMode && !split_header_flag && facts.bufLen == 16'h0000) begin
            parsed_header_length = facts.pktLen[9:0]; // [R8]
        end
        if (facts.inlineTs) begin
            parsed_header_length = parsed_header_length + INLINE_TS_BYTES[9:0]; // [R6]
            packet_buffer_length = packet_buffer_length + INLINE_TS_BYTES; // [R6]
        end
        if (!facts.firstDesc) begin
            parsed_header_length = 10'h000; // [R5]
        end
        // shared hash or fragment checksum word
        if (checksum_disable_ctl) begin
            sharedField = facts.rssHash; // [R10]
        end else if (ip_payload_sum_enable) begin
            sharedField = {facts.fragSum, facts.ipId}; // [R9]
        end else begin
            sharedField = 32'h0000_0000;
        end
        // extended status; untouched bits stay reserved zero
        extStatus = 20'h00000; // [R14]
        extStatus[ST_DONE] = 1'b1; // [R24]
        extError = 12'h000;
        if (facts.lastDesc) begin
            extStatus[ST_EOP] = 1'b1; // [R24]
            extStatus[ST_VLAN_STRIP] = facts.vlanStrip;
            extStatus[ST_UDP_DONE] = facts.udpSumDone;
            extStatus[ST_L4_DONE] = facts.l4Done && (facts.pktType[PT_TCP_BIT] ||
                facts.pktType[PT_UDP_BIT] || facts.pktType[PT_SCTP_BIT]); // [R15]
            extStatus[ST_IP_DONE] = facts.ipSumDone;
            extStatus[ST_INEXACT] = facts.inexact;
            extStatus[ST_OUTER_VLAN] = facts.outerVlan && double_vlan_enable; // [R16]
            extStatus[ST_FRAG_UDP] = facts.fragUdpHdr && (facts.fragSum != 16'h0000); // [R17]
            extStatus[ST_LLI] = facts.lliHit; // [R18]
            extStatus[ST_CRC_STRIP] = facts.crcStripped && strip_crc_ctl; // [R19]
            extStatus[ST_INLINE_TS] = facts.inlineTs; // [R13]
            extStatus[ST_SYNC_TS] = facts.syncTs; // [R12]
            extError[ER_DATA] = facts.dataErr; // [R20]
            extError[ER_IP] = facts.ipSumBad && facts.ipSumDone; // [R20]
            extError[ER_L4] = facts.l4Bad && extStatus[ST_L4_DONE]; // [R20]
            extError[ER_HDR_OVF] = header_overflow && split_header_flag; // [R20] [R21]
        end // else only done set, end-of-packet clear [R11]
        next_desc.word0 = {sharedField, split_header_flag, parsed_header_length,
                           4'h0, pktTypeOut, hashOut}; // [R25]
        next_desc.word1 = {facts.vlanTag, packet_buffer_length, extError,
                           extStatus}; // [R23] [R25]
    end

    // descriptor output register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            desc <= '0;
            descValid <= 1'b0;
        end else begin
            descValid <= factsValid;
            if (factsValid) begin
                desc <= next_desc;
            end
        end
    end

    // written descriptor counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            descCount <= 16'h0000;
        end else if (factsValid) begin
            descCount <= descCount + 16'h0001;
        end
    end

    // apb control register write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (psel && penable && pwrite && paddr == REG_CTRL) begin
            ctrl <= pwdata;
        end
    end

    // apb read and response, one access cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == REG_CTRL) begin
                    prdata <= ctrl;
                end else if (paddr == REG_STATUS) begin
                    prdata <= {31'h0, descValid};
                end else if (paddr == REG_WORD0_LO) begin
                    prdata <= desc.word0[31:0];
                end else if (paddr == REG_WORD0_HI) begin
                    prdata <= desc.word0[63:32];
                end else if (paddr == REG_WORD1_LO) begin
                    prdata <= desc.word1[31:0];
                end else if (paddr == REG_WORD1_HI) begin
                    prdata <= desc.word1[63:32];
                end else if (paddr == REG_COUNT) begin
                    prdata <= {16'h0000, descCount};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // reserved status bits never set
    reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
        descValid |-> (desc.word1[19:17] == 3'h0 && desc.word1[14:13] == 2'h0 &&
                       desc.word1[8] == 1'b0 && desc.word1[2] == 1'b0))
        else $error("reserved status bit set");
    // non-last descriptor has only done
    nonlast_status_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
        factsValid && !facts.lastDesc |=> desc.word1[19:0] == 20'h00001)
        else $error("non-last status wrong");
    // done and end together on last
    last_done_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R24]
        factsValid && facts.lastDesc |=> desc.word1[1:0] == 2'h3)
        else $error("last descriptor not complete");
    // hash selected by checksum disable
    hash_select_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
        factsValid && checksum_disable_ctl |=> desc.word0[63:32] == $past(facts.rssHash))
        else $error("hash not written");
    // fragment checksum placement
    frag_sum_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
        factsValid && !checksum_disable_ctl && ip_payload_sum_enable
        |=> desc.word0[63:48] == $past(facts.fragSum) &&
            desc.word0[47:32] == $past(facts.ipId))
        else $error("fragment checksum misplaced");
    // reserved hash codes absent
    hash_code_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
        descValid |-> desc.word0[3:0] <= HASH_LAST_VALID)
        else $error("reserved hash code");
    // outer vlan gated by control
    outer_vlan_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
        factsValid && !double_vlan_enable |=> !desc.word1[ST_OUTER_VLAN])
        else $error("outer vlan without control");
    // overflow only with split flag
    overflow_split_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R21]
        descValid && desc.word1[32 + ER_HDR_OVF - 12] |-> desc.word0[31])
        else $error("overflow without split");
    // apb answers one cycle after setup
    apb_ready_a: assert property (@(posedge mclk) disable iff (!rst_n)
        psel && !penable |=> pready)
        else $error("apb not ready");
endmodule : rx_descriptor_writeback_format

// *** verification/host_mem_model.sv ***
// host memory ring that receives written-back descriptors
`timescale 1ns/1ps
module host_mem_model
    import rx_wb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic descValid,
    input wire rx_wb_pkg::wb_desc_t desc,
    output logic [63:0] memWord0,
    output logic [63:0] memWord1,
    output logic [15:0] ownedCount
);
    wb_desc_t ring [16];
    logic [3:0] head;
    logic midPacket;
    // store each descriptor; header length of later ones is dropped by software
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            head <= 4'h0;
            midPacket <= 1'b0;
            memWord0 <= '0;
            memWord1 <= '0;
        end else if (descValid) begin
            ring[head] <= desc;
            head <= head + 4'h1;
            midPacket <= !desc.word1[ST_EOP];
            memWord0 <= midPacket ? {desc.word0[63:31], 10'h000, desc.word0[20:0]} : desc.word0;
            memWord1 <= desc.word1;
        end
    end
    // ownership passes only with done and end-of-packet together
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ownedCount <= 16'h0000;
        end else if (descValid && desc.word1[ST_DONE] && desc.word1[ST_EOP]) begin
            ownedCount <= ownedCount + 16'h0001;
        end
    end
endmodule : host_mem_model

// *** verification/rx_descriptor_writeback_format_bench.sv ***
// testbench for the write-back descriptor assembler
`timescale 1ns/1ps
module rx_descriptor_writeback_format_bench;
    import rx_wb_pkg::*;
    logic mclk, rst_n, factsValid, psel, penable, pwrite, pready, pslverr, descValid, rdErr;
    logic [9:0] headerBufSize;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic [63:0] memWord0, memWord1;
    logic [15:0] ownedCount;
    rx_facts_t facts, fb;
    wb_desc_t desc;
    int errCount, checked, sent, cycles;
    rx_descriptor_writeback_format rx_descriptor_writeback_format_inst (.mclk(mclk),
        .rst_n(rst_n), .factsValid(factsValid), .facts(facts),
        .header_buffer_size(headerBufSize), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .descValid(descValid), .desc(desc));
    host_mem_model host_mem_model_inst (.mclk(mclk), .rst_n(rst_n), .descValid(descValid),
        .desc(desc), .memWord0(memWord0), .memWord1(memWord1), .ownedCount(ownedCount));
    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 2000) begin
            errCount++;
            finalReport();
        end
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // wait for the slave; only the bench timeout ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // one descriptor; answer due exactly one cycle later
    task automatic send(input rx_facts_t f);
        int n;
        n = 0;
        facts <= f;
        factsValid <= 1'b1;
        @(posedge mclk);
        factsValid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (descValid !== 1'b1 && n < 4);
        check("descValid latency", n, 1);
        sent++;
    endtask : send
    function automatic rx_facts_t allFlags();
        rx_facts_t f;
        f = fb;
        {f.outerVlan, f.ipSumDone, f.ipSumBad, f.l4Done, f.l4Bad, f.udpSumDone} = 6'h3f;
        {f.fragUdpHdr, f.inexact, f.lliHit, f.crcStripped, f.syncTs, f.dataErr} = 6'h3f;
        return f;
    endfunction : allFlags
    task automatic testRegs();
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", rdData, CTRL_RESET);
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped read err", {rdErr, rdData}, 33'h100000000);
        apb(1'b1, REG_CTRL, 32'h0000001d);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl write", rdData, 32'h0000001d);
        apb(1'b1, REG_CTRL, CTRL_RESET);
    endtask : testRegs
    task automatic testHash();
        rx_facts_t f;
        logic [12:0] pts [3] = '{13'h1011, 13'h0fff, 13'h17ff};
        logic [12:0] ptExp [3] = '{13'h1011, 13'h0807, 13'h10ff};
        f = fb;
        for (int c = 0; c < 16; c++) begin
            f.hashType = c[3:0];
            send(f);
            check("hash type", desc.word0[3:0], (c <= 9) ? c[3:0] : HASH_NONE);
        end
        check("word0", desc.word0, {f.rssHash, 1'b0, f.hdrLen, 4'h0, f.pktType, HASH_NONE});
        check("word1", desc.word1, {f.vlanTag, f.bufLen, 12'h000, 20'h0000b});
        for (int i = 0; i < 3; i++) begin
            f.pktType = pts[i];
            send(f);
            check("packet type", desc.word0[16:4], ptExp[i]);
        end
    endtask : testHash
    task automatic testShared();
        apb(1'b1, REG_CTRL, 32'h00000012);
        send(fb);
        check("frag sum and id", desc.word0[63:32], {fb.fragSum, fb.ipId});
        apb(1'b1, REG_CTRL, 32'h00000010);
        send(fb);
        check("shared off", desc.word0[63:32], 0);
    endtask : testShared
    task automatic testStatus();
        rx_facts_t f;
        apb(1'b1, REG_CTRL, 32'h0000001d);
        f = allFlags();
        send(f);
        check("status", desc.word1[19:0], 20'h11efb);
        check("errors", desc.word1[31:20], 12'he00);
        check("sync ts", desc.word1[ST_SYNC_TS], 1);
        check("l4 done", desc.word1[ST_L4_DONE], 1);
        check("outer vlan", desc.word1[ST_OUTER_VLAN], 1);
        check("lli", desc.word1[ST_LLI], 1);
        check("crc strip", desc.word1[ST_CRC_STRIP], 1);
        @(posedge mclk);
        check("host copy", memWord1, {f.vlanTag, f.bufLen, 12'he00, 20'h11efb});
        check("host word0", memWord0, {f.rssHash, 1'b0, f.hdrLen, 4'h0, f.pktType, f.hashType});
        f.fragUdpHdr = 1'b0;
        send(f);
        check("frag udp", desc.word1[ST_FRAG_UDP], 0);
        f.pktType = 13'h1001;
        send(f);
        check("l4 without type", desc.word1[ST_L4_DONE], 0);
        check("l4 err without type", desc.word1[20 + ER_L4], 0);
        f = allFlags();
        f.lastDesc = 1'b0;
        send(f);
        check("mid status", desc.word1[19:0], 20'h00001);
        f.lastDesc = 1'b1;
        f.firstDesc = 1'b0;
        send(f);
        check("later parsed_header_length", desc.word0[30:21], 0);
    endtask : testStatus
    task automatic testLengths();
        rx_facts_t f;
        apb(1'b1, REG_CTRL, CTRL_RESET);
        f = fb;
        f.inlineTs = 1'b1;
        send(f);
        check("ts lengths", {desc.word0[30:21], desc.word1[47:32]}, {10'd56, 16'd116});
        check("inline ts", desc.word1[ST_INLINE_TS], 1);
        apb(1'b1, REG_CTRL, 32'h00000031);
        f = fb;
        {f.hdrLen, f.hdrFits, f.splitUsed} = {10'd100, 1'b0, 1'b1};
        send(f);
        check("repl sph len", desc.word0[31:21], {1'b1, 10'd100});
        check("hdr overflow", desc.word1[20 + ER_HDR_OVF], 1);
        apb(1'b1, REG_CTRL, 32'h00000041);
        f = fb;
        {f.pktLen, f.bufLen, f.hdrLen} = {16'd30, 16'd0, 10'd20};
        send(f);
        check("small packet_buffer_length", desc.word1[47:32], 16'd30);
        apb(1'b1, REG_CTRL, 32'h00000051);
        f = fb;
        {f.pktLen, f.bufLen, f.splitUsed} = {16'd50, 16'd0, 1'b0};
        send(f);
        check("always parsed_header_length", desc.word0[31:21], {1'b0, 10'd50});
        apb(1'b0, REG_COUNT, 32'h0);
        check("desc count", rdData, sent);
        check("owned count", ownedCount, sent - 1);
    endtask : testLengths
    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finalReport
    initial begin
        {rst_n, factsValid, psel, penable, pwrite, paddr, pwdata} = '0;
        facts = '0;
        headerBufSize = 10'd64;
        {errCount, checked, sent, cycles} = '0;
        fb = '{lastDesc: 1'b1, firstDesc: 1'b1, hashType: 4'h1, pktType: 13'h1011,
            hdrLen: 10'd40, hdrFits: 1'b1, bufLen: 16'd100, pktLen: 16'd100,
            rssHash: 32'hcafef00d, fragSum: 16'h1234, ipId: 16'h5678, vlanTag: 16'ha005,
            vlanStrip: 1'b1, default: '0};
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        testRegs();
        testHash();
        testShared();
        testStatus();
        testLengths();
        finalReport();
    end
endmodule : rx_descriptor_writeback_format_bench
